// file: common/slirq_defines.vh
`ifndef SLIRQ_DEFINES_VH
`define SLIRQ_DEFINES_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define SLIRQ_IDX_DISP_LANES   11'h46d
`define SLIRQ_IDX_INV_LANES    11'h46e
`define SLIRQ_IDX_STRAY_LANES  11'h46f
`define SLIRQ_IDX_LOCK_FLAGS   11'h470
`define SLIRQ_IDX_FRAME_FLAGS  11'h471
`define SLIRQ_IDX_SUM_FLAGS    11'h472
`define SLIRQ_IDX_ALIGN_FLAGS  11'h473
`define SLIRQ_IDX_OPF_CFG      11'h476
`define SLIRQ_IDX_TEST_CTRL    11'h477
`define SLIRQ_IDX_ILAS_COUNT   11'h478
`define SLIRQ_IDX_IRQ_VECTOR   11'h47a
`define SLIRQ_IDX_ERR_LIMIT    11'h47c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SLIRQ_BIT_IRQ_CLEAR    7
`define SLIRQ_BIT_TEST_SELECT  7
`define SLIRQ_BIT_THRESH_EN    3
`define SLIRQ_BIT_DISPARITY    7
`define SLIRQ_BIT_INVALID      6
`define SLIRQ_BIT_STRAY        5
`define SLIRQ_BIT_RESERVED     4
`define SLIRQ_BIT_LANE_ALIGN   3
`define SLIRQ_BIT_CFG_SUM      2
`define SLIRQ_BIT_FRAME_LOCK   1
`define SLIRQ_BIT_SYMBOL_LOCK  0

// ----------------------------------------------------------------------
// Reset values and legal settings
// ----------------------------------------------------------------------
`define SLIRQ_RST_OPF          8'h01
`define SLIRQ_RST_ILAS_COUNT   8'h01
`define SLIRQ_RST_ERR_LIMIT    8'hff
`define SLIRQ_RST_MASK         8'h00
`define SLIRQ_OPF_ONE          8'h01
`define SLIRQ_OPF_TWO          8'h02
`define SLIRQ_OPF_FOUR         8'h04
`define SLIRQ_ILAS_FORBIDDEN   8'h00

`endif

// file: core/slirq_sync2.v
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for lane status levels
module slirq_sync2 #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             mclk,
  input  wire             reset,
  // Data
  input  wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1_r;
  reg [WIDTH-1:0] stage2_r;

  // First stage feeds only the second stage
  always @(posedge mclk)
  begin
    if (reset)
    begin
      stage1_r <= {WIDTH{1'b0}};
      stage2_r <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1_r <= asyncIn;
      stage2_r <= stage1_r;
    end
  end

  assign syncOut = stage2_r;

endmodule // slirq_sync2

`default_nettype wire

// file: core/slirq_err_cnt.v
`timescale 1ns/1ps
`default_nettype none

// One lane, one error kind: saturating count and sticky limit flag
module slirq_err_cnt #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             mclk,
  input  wire             reset,
  // Error event and software clear
  input  wire             errPulse,
  input  wire             clearCount,
  input  wire [WIDTH-1:0] countLimit,
  // Status
  output wire             limitHit
);

  reg [WIDTH-1:0] count_r;
  reg             hit_r;

  // Next count restarts on clear and holds at all ones
  wire             atMax     = (count_r == {WIDTH{1'b1}});
  wire [WIDTH-1:0] count_nxt = clearCount ? {{(WIDTH-1){1'b0}}, errPulse}
                             : count_r + {{(WIDTH-1){1'b0}}, errPulse & ~atMax};

  // Saturate so a long error burst cannot wrap below the limit
  always @(posedge mclk)
  begin
    if (reset)
    begin
      count_r <= {WIDTH{1'b0}};
      hit_r   <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      // Set wins over a clear; judged on the next count so a clear sticks
      hit_r   <= (count_nxt >= countLimit) | (hit_r & ~clearCount);
    end
  end

  assign limitHit = hit_r;

endmodule // slirq_err_cnt

`default_nettype wire

// file: core/slirq_top.v
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "slirq_defines.vh"

// Operation
// - Per-lane lane alignment status in eight bits; writing 1 to bit 7 clears its interrupt.
// - Lane alignment summary flag sits at bit 3 of the interrupt vector.
// - Lost lane alignment also raises a sync request on the lane group's sync output.
// - Octets per frame takes only 1, 2 or 4; resets to 1.
// - Test select bit makes receiver treat link as constant alignment frames; resets 0.
// - Alignment length field times four gives multiframes; resets to 1, zero refused.
// - Mask bit 7 with any lane disparity count at limit pulls interrupt low.
// - Mask bit 6 with any lane invalid symbol count at limit pulls interrupt low.
// - Mask bit 5 with any lane stray control count at limit pulls interrupt low.
// - Mask bit 3 with failed lane alignment pulls interrupt low; bit 4 reserved.
// - Mask bit 2 with a bad configuration checksum pulls interrupt low.
// - Mask bit 1 with lost frame lock on any lane pulls interrupt low.
// - Summary bit 7 reads 1 when any lane disparity count reached the limit.
// - Summary bit 6 reads 1 when any lane invalid symbol count reached the limit.
// - Mask and summary share one address: writes go to masks, reads return flags.
// - Three error kinds counted per lane against one shared limit resetting to 255.
// - Bit x of each per-lane error register sets when lane x count reaches limit.
module slirq_top #(
  parameter LANES = 8,
  parameter CNT_W = 8
) (
  // Clock and reset
  input  wire             mclk,
  input  wire             reset,
  // APB slave
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [12:0]      paddr,
  input  wire [31:0]      pwdata,
  output wire [31:0]      prdata,
  output wire             pready,
  output wire             pslverr,
  // Lane status levels from the deserialiser (1 = locked / good)
  input  wire [LANES-1:0] symbolLockIn,
  input  wire [LANES-1:0] frameLockIn,
  input  wire [LANES-1:0] laneAlignIn,
  input  wire [LANES-1:0] cfgSumGoodIn,
  // Per-lane error pulses, same clock
  input  wire [LANES-1:0] disparityErr,
  input  wire [LANES-1:0] invalidSymbolErr,
  input  wire [LANES-1:0] strayCtrlErr,
  // Link configuration outputs
  output wire [7:0]       octetsPerFrame,
  output wire             alignSeqTestSelect,
  output wire             thresholdMaskEn,
  output wire [7:0]       alignSeqLength,
  output wire [9:0]       alignSeqMultiframes,
  // Link sync requests, active low, lanes 0-3 and 4-7
  output wire [1:0]       linkSyncRequestOut_n,
  // Interrupt, active low
  output wire             irq_n
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------

  // Any lane dropped from good to bad since last cycle
  function anyLoss;
    input [LANES-1:0] prevLevel;
    input [LANES-1:0] curLevel;
    begin
      anyLoss = |(prevLevel & ~curLevel);
    end
  endfunction

  // Register index hit for the current APB address
  function isIdx;
    input [12:0] addr;
    input [10:0] idx;
    begin
      isIdx = (addr[12:2] == idx) && (addr[1:0] == 2'b00);
    end
  endfunction

  // --------------------------------------------------------------------
  // Status synchronisers
  // --------------------------------------------------------------------

  wire [LANES-1:0] symbolLock;
  wire [LANES-1:0] frameLock;
  wire [LANES-1:0] laneAlign;
  wire [LANES-1:0] cfgSumGood;

  slirq_sync2 #(
    .WIDTH   (4*LANES)
  ) uStatusSync (
    .mclk    (mclk),
    .reset   (reset),
    .asyncIn ({symbolLockIn, frameLockIn, laneAlignIn, cfgSumGoodIn}),
    .syncOut ({symbolLock, frameLock, laneAlign, cfgSumGood})
  );

  // --------------------------------------------------------------------
  // Bus access decode
  // --------------------------------------------------------------------

  reg  pready_r;
  wire wrEn = psel && penable && pwrite && pready_r;
  wire setupCycle = psel && !penable;

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------

  reg [7:0]        opf_r;
  reg              testSelect_r;
  reg              threshEn_r;
  reg [7:0]        ilasCount_r;
  reg [9:0]        ilasFrames_r;
  reg [7:0]        irqMask_r;
  reg [CNT_W-1:0]  errLimit_r;

  // Illegal settings are refused so the link never sees them
  always @(posedge mclk)
  begin
    if (reset)
    begin
      opf_r        <= `SLIRQ_RST_OPF;
      testSelect_r <= 1'b0;
      threshEn_r   <= 1'b0;
      ilasCount_r  <= `SLIRQ_RST_ILAS_COUNT;
      ilasFrames_r <= {`SLIRQ_RST_ILAS_COUNT, 2'b00};
      irqMask_r    <= `SLIRQ_RST_MASK;
      errLimit_r   <= `SLIRQ_RST_ERR_LIMIT;
    end
    else if (wrEn)
    begin
      if (isIdx(paddr, `SLIRQ_IDX_OPF_CFG))
      begin
        if ((pwdata[7:0] == `SLIRQ_OPF_ONE) || (pwdata[7:0] == `SLIRQ_OPF_TWO) ||
            (pwdata[7:0] == `SLIRQ_OPF_FOUR))
          opf_r <= pwdata[7:0];
      end
      else if (isIdx(paddr, `SLIRQ_IDX_TEST_CTRL))
      begin
        testSelect_r <= pwdata[`SLIRQ_BIT_TEST_SELECT];
        threshEn_r   <= pwdata[`SLIRQ_BIT_THRESH_EN];
      end
      else if (isIdx(paddr, `SLIRQ_IDX_ILAS_COUNT))
      begin
        if (pwdata[7:0] != `SLIRQ_ILAS_FORBIDDEN)
        begin
          ilasCount_r  <= pwdata[7:0];
          ilasFrames_r <= {pwdata[7:0], 2'b00};
        end
      end
      else if (isIdx(paddr, `SLIRQ_IDX_IRQ_VECTOR))
      begin
        irqMask_r <= pwdata[7:0] & ~(8'h01 << `SLIRQ_BIT_RESERVED);
      end
      else if (isIdx(paddr, `SLIRQ_IDX_ERR_LIMIT))
      begin
        errLimit_r <= pwdata[CNT_W-1:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // Per-lane error counters
  // --------------------------------------------------------------------

  // Writing 1 to bit x of a lane register clears lane x of that kind
  wire [LANES-1:0] dispClr  = (wrEn && isIdx(paddr, `SLIRQ_IDX_DISP_LANES))
                              ? pwdata[LANES-1:0] : {LANES{1'b0}};
  wire [LANES-1:0] invClr   = (wrEn && isIdx(paddr, `SLIRQ_IDX_INV_LANES))
                              ? pwdata[LANES-1:0] : {LANES{1'b0}};
  wire [LANES-1:0] strayClr = (wrEn && isIdx(paddr, `SLIRQ_IDX_STRAY_LANES))
                              ? pwdata[LANES-1:0] : {LANES{1'b0}};
  wire [LANES-1:0] dispHit;
  wire [LANES-1:0] invHit;
  wire [LANES-1:0] strayHit;

  genvar lane;
  generate
    for (lane = 0; lane < LANES; lane = lane + 1)
    begin : gLane
      // Shared limit across all lanes and kinds
      slirq_err_cnt #(.WIDTH(CNT_W)) uDisp (
        .mclk       (mclk),
        .reset      (reset),
        .errPulse   (disparityErr[lane]),
        .clearCount (dispClr[lane]),
        .countLimit (errLimit_r),
        .limitHit   (dispHit[lane])
      );
      slirq_err_cnt #(.WIDTH(CNT_W)) uInv (
        .mclk       (mclk),
        .reset      (reset),
        .errPulse   (invalidSymbolErr[lane]),
        .clearCount (invClr[lane]),
        .countLimit (errLimit_r),
        .limitHit   (invHit[lane])
      );
      slirq_err_cnt #(.WIDTH(CNT_W)) uStray (
        .mclk       (mclk),
        .reset      (reset),
        .errPulse   (strayCtrlErr[lane]),
        .clearCount (strayClr[lane]),
        .countLimit (errLimit_r),
        .limitHit   (strayHit[lane])
      );
    end
  endgenerate

  // --------------------------------------------------------------------
  // Lock loss latches
  // --------------------------------------------------------------------

  reg [LANES-1:0] symbolPrev_r;
  reg [LANES-1:0] framePrev_r;
  reg [LANES-1:0] alignPrev_r;
  reg [LANES-1:0] sumPrev_r;
  reg             symbolFail_r;
  reg             frameFail_r;
  reg             alignFail_r;
  reg             sumFail_r;

  wire clrSymbol = wrEn && isIdx(paddr, `SLIRQ_IDX_LOCK_FLAGS) &&
                   pwdata[`SLIRQ_BIT_IRQ_CLEAR];
  wire clrFrame  = wrEn && isIdx(paddr, `SLIRQ_IDX_FRAME_FLAGS) &&
                   pwdata[`SLIRQ_BIT_IRQ_CLEAR];
  wire clrAlign  = wrEn && isIdx(paddr, `SLIRQ_IDX_ALIGN_FLAGS) &&
                   pwdata[`SLIRQ_BIT_IRQ_CLEAR];
  wire clrSum    = wrEn && isIdx(paddr, `SLIRQ_IDX_SUM_FLAGS) &&
                   pwdata[`SLIRQ_BIT_IRQ_CLEAR];

  // Edge-based so lanes that never locked after reset do not fire
  always @(posedge mclk)
  begin
    if (reset)
    begin
      symbolPrev_r <= {LANES{1'b0}};
      framePrev_r  <= {LANES{1'b0}};
      alignPrev_r  <= {LANES{1'b0}};
      sumPrev_r    <= {LANES{1'b0}};
      symbolFail_r <= 1'b0;
      frameFail_r  <= 1'b0;
      alignFail_r  <= 1'b0;
      sumFail_r    <= 1'b0;
    end
    else
    begin
      symbolPrev_r <= symbolLock;
      framePrev_r  <= frameLock;
      alignPrev_r  <= laneAlign;
      sumPrev_r    <= cfgSumGood;
      // A loss in the clearing cycle keeps the flag set
      symbolFail_r <= anyLoss(symbolPrev_r, symbolLock) | (symbolFail_r & ~clrSymbol);
      frameFail_r  <= anyLoss(framePrev_r, frameLock) | (frameFail_r & ~clrFrame);
      alignFail_r  <= anyLoss(alignPrev_r, laneAlign) | (alignFail_r & ~clrAlign);
      sumFail_r    <= anyLoss(sumPrev_r, cfgSumGood) | (sumFail_r & ~clrSum);
    end
  end

  // --------------------------------------------------------------------
  // Summary vector and interrupt
  // --------------------------------------------------------------------

  reg [7:0] summary;
  always @*
  begin
    summary = 8'h00;
    summary[`SLIRQ_BIT_DISPARITY]   = |dispHit;
    summary[`SLIRQ_BIT_INVALID]     = |invHit;
    summary[`SLIRQ_BIT_STRAY]       = |strayHit;
    summary[`SLIRQ_BIT_LANE_ALIGN]  = alignFail_r;
    summary[`SLIRQ_BIT_CFG_SUM]     = sumFail_r;
    summary[`SLIRQ_BIT_FRAME_LOCK]  = frameFail_r;
    summary[`SLIRQ_BIT_SYMBOL_LOCK] = symbolFail_r;
  end

  reg irqN_r;
  reg [1:0] syncReqN_r;

  // Level interrupt: low while any enabled flag stays latched
  always @(posedge mclk)
  begin
    if (reset)
      irqN_r <= 1'b1;
    else
      irqN_r <= ~|(summary & irqMask_r);
  end

  // Sync request held while any lane of the group lacks symbol lock or lane alignment
  always @(posedge mclk)
  begin
    if (reset)
      syncReqN_r <= 2'b00;
    else
    begin
      syncReqN_r[0] <= &(laneAlign[3:0] & symbolLock[3:0]);
      syncReqN_r[1] <= &(laneAlign[LANES-1:4] & symbolLock[LANES-1:4]);
    end
  end

  // --------------------------------------------------------------------
  // APB read path and handshake
  // --------------------------------------------------------------------

  reg [31:0] prdata_r;
  reg        pslverr_r;
  reg [7:0]  rdValue;
  reg        rdHit;

  // Read mux; masks are write-only so the vector address returns flags
  always @*
  begin
    rdValue = 8'h00;
    rdHit   = 1'b1;
    if (isIdx(paddr, `SLIRQ_IDX_DISP_LANES))
      rdValue = dispHit;
    else if (isIdx(paddr, `SLIRQ_IDX_INV_LANES))
      rdValue = invHit;
    else if (isIdx(paddr, `SLIRQ_IDX_STRAY_LANES))
      rdValue = strayHit;
    else if (isIdx(paddr, `SLIRQ_IDX_LOCK_FLAGS))
      rdValue = symbolLock;
    else if (isIdx(paddr, `SLIRQ_IDX_FRAME_FLAGS))
      rdValue = frameLock;
    else if (isIdx(paddr, `SLIRQ_IDX_SUM_FLAGS))
      rdValue = cfgSumGood;
    else if (isIdx(paddr, `SLIRQ_IDX_ALIGN_FLAGS))
      rdValue = laneAlign;
    else if (isIdx(paddr, `SLIRQ_IDX_OPF_CFG))
      rdValue = opf_r;
    else if (isIdx(paddr, `SLIRQ_IDX_TEST_CTRL))
      rdValue = {testSelect_r, 3'b000, threshEn_r, 3'b000};
    else if (isIdx(paddr, `SLIRQ_IDX_ILAS_COUNT))
      rdValue = ilasCount_r;
    else if (isIdx(paddr, `SLIRQ_IDX_IRQ_VECTOR))
      rdValue = summary;
    else if (isIdx(paddr, `SLIRQ_IDX_ERR_LIMIT))
      rdValue = errLimit_r;
    else
      rdHit = 1'b0;
  end

  // No wait state: ready rises the cycle after setup, data registered
  always @(posedge mclk)
  begin
    if (reset)
    begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end
    else if (setupCycle)
    begin
      pready_r  <= 1'b1;
      prdata_r  <= pwrite ? 32'h00000000 : {24'h000000, rdValue};
      pslverr_r <= ~rdHit;
    end
    else
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Output drive
  // --------------------------------------------------------------------

  assign prdata               = prdata_r;
  assign pready               = pready_r;
  assign pslverr              = pslverr_r;
  assign octetsPerFrame       = opf_r;
  assign alignSeqTestSelect   = testSelect_r;
  assign thresholdMaskEn      = threshEn_r;
  assign alignSeqLength       = ilasCount_r;
  assign alignSeqMultiframes  = ilasFrames_r;
  assign linkSyncRequestOut_n = syncReqN_r;
  assign irq_n                = irqN_r;

endmodule // slirq_top

`default_nettype wire

// file: tb/slirq_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "slirq_defines.vh"

// ----------------------------------------
// Port checker for the link irq block
// ----------------------------------------
module slirq_top_sva (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        reset,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [12:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Lane status
  input wire logic [7:0]  laneAlignIn,
  // Watched outputs
  input wire logic [7:0]  octetsPerFrame,
  input wire logic        alignSeqTestSelect,
  input wire logic        thresholdMaskEn,
  input wire logic [7:0]  alignSeqLength,
  input wire logic [9:0]  alignSeqMultiframes,
  input wire logic [1:0]  linkSyncRequestOut_n,
  input wire logic        irq_n
);
  localparam logic [12:0] A_OPF  = {`SLIRQ_IDX_OPF_CFG, 2'b00};
  localparam logic [12:0] A_TEST = {`SLIRQ_IDX_TEST_CTRL, 2'b00};
  localparam logic [12:0] A_VEC  = {`SLIRQ_IDX_IRQ_VECTOR, 2'b00};
  logic maskSeen_r, maskSeen_nxt;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // No irq before a non-zero mask lands
  assign maskSeen_nxt = maskSeen_r | (psel & penable & pready & pwrite & (paddr == A_VEC)
                        & (|pwdata[7:0]));
  always @(posedge mclk)
    maskSeen_r <= reset ? 1'b0 : maskSeen_nxt;

  property p_apb_answer;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("setup not answered");
  property p_unmapped;
    pready && paddr[12:2] == 11'h474 |-> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  property p_vec_read;
    pready && !pwrite && paddr == A_VEC |-> !pslverr && prdata[4] == 1'b0 && prdata[31:8] == 0;
  endproperty
  a_vec_read: assert property (p_vec_read) else $error("summary reserved bit set");
  property p_ctrl_read;
    pready && !pwrite && paddr == A_TEST |-> (prdata & 32'hffffff77) == 32'h0;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("ctrl reserved bit set");
  property p_opf_legal;
    octetsPerFrame inside {8'h01, 8'h02, 8'h04};
  endproperty
  a_opf_legal: assert property (p_opf_legal) else $error("octets illegal");
  property p_len;
    alignSeqLength != 8'h00 && alignSeqMultiframes == {alignSeqLength, 2'b00};
  endproperty
  a_len: assert property (p_len) else $error("multiframes not four times length");
  property p_opf_write;
    pready && pwrite && paddr == A_OPF && pwdata[7:0] inside {8'h01, 8'h02, 8'h04}
      |=> octetsPerFrame == $past(pwdata[7:0]);
  endproperty
  a_opf_write: assert property (p_opf_write) else $error("octets write lost");
  property p_test_write;
    pready && pwrite && paddr == A_TEST
      |=> alignSeqTestSelect == $past(pwdata[7]) && thresholdMaskEn == $past(pwdata[3]);
  endproperty
  a_test_write: assert property (p_test_write) else $error("ctrl write lost");
  property p_irq_quiet;
    !maskSeen_r |-> irq_n;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq with masks clear");
  property p_irq_hold;
    !irq_n && !(psel && pwrite) && !$past(psel && pwrite) |=> !irq_n;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq released alone");
  property p_sync0;
    (laneAlignIn[3:0] != 4'hf) [*4] |-> !linkSyncRequestOut_n[0];
  endproperty
  a_sync0: assert property (p_sync0) else $error("no request, lanes 0-3");
  property p_sync1;
    (laneAlignIn[7:4] != 4'hf) [*4] |-> !linkSyncRequestOut_n[1];
  endproperty
  a_sync1: assert property (p_sync1) else $error("no request, lanes 4-7");

  // Main scenarios reached
  c_irq: cover property (!irq_n);
  c_err: cover property (pready && pslverr);
  c_sync: cover property (!linkSyncRequestOut_n[1]);
endmodule // slirq_top_sva
`default_nettype wire

// file: tb/slirq_lane_model.sv
`timescale 1ns/1ps
`default_nettype none

// Far-side transmitter: lane levels (1 = good) and error pulses
module slirq_lane_model (
  // Clock
  input  wire logic mclk,
  // Lane levels
  output logic [7:0] symbolLock,
  output logic [7:0] frameLock,
  output logic [7:0] cfgSumGood,
  output logic [7:0] laneAlign,
  // One-cycle error pulses
  output logic [7:0] disparityErr,
  output logic [7:0] invalidSymbolErr,
  output logic [7:0] strayCtrlErr
);
  // Healthy link at start
  logic [3:0][7:0] level = '1;
  logic [2:0][7:0] pulse = '0;
  assign symbolLock       = level[0];
  assign frameLock        = level[1];
  assign cfgSumGood       = level[2];
  assign laneAlign        = level[3];
  assign disparityErr     = pulse[0];
  assign invalidSymbolErr = pulse[1];
  assign strayCtrlErr     = pulse[2];

  // Level change right after an edge
  task automatic setLevel(input int k, input int lane, input logic v);
    @(posedge mclk);
    level[k][lane] <= v;
  endtask

  // Spaced pulses, each counted once
  task automatic burst(input int k, input int lane, input int n);
    repeat (n)
    begin
      @(posedge mclk);
      pulse[k][lane] <= 1'b1;
      @(posedge mclk);
      pulse[k][lane] <= 1'b0;
    end
  endtask
endmodule // slirq_lane_model
`default_nettype wire

// file: tb/slirq_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "slirq_defines.vh"

module tb;
  logic        mclk, reset, psel, penable, pwrite, pready, pslverr, irq_n;
  logic        alignSeqTestSelect, thresholdMaskEn;
  logic [12:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  symbolLock, frameLock, cfgSumGood, laneAlign;
  logic [7:0]  disparityErr, invalidSymbolErr, strayCtrlErr;
  logic [7:0]  octetsPerFrame, alignSeqLength;
  logic [9:0]  alignSeqMultiframes;
  logic [1:0]  linkSyncRequestOut_n;
  int          mismatches, testsRun;

  slirq_top u_slirq_top (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .symbolLockIn(symbolLock), .frameLockIn(frameLock), .laneAlignIn(laneAlign),
    .cfgSumGoodIn(cfgSumGood), .disparityErr(disparityErr),
    .invalidSymbolErr(invalidSymbolErr), .strayCtrlErr(strayCtrlErr),
    .octetsPerFrame(octetsPerFrame), .alignSeqTestSelect(alignSeqTestSelect),
    .thresholdMaskEn(thresholdMaskEn), .alignSeqLength(alignSeqLength),
    .alignSeqMultiframes(alignSeqMultiframes),
    .linkSyncRequestOut_n(linkSyncRequestOut_n), .irq_n(irq_n));

  slirq_lane_model u_model (
    .mclk(mclk), .symbolLock(symbolLock), .frameLock(frameLock), .cfgSumGood(cfgSumGood),
    .laneAlign(laneAlign), .disparityErr(disparityErr),
    .invalidSymbolErr(invalidSymbolErr), .strayCtrlErr(strayCtrlErr));

  // 200 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready
  task automatic xfer(input logic wr, input logic [10:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd, output logic err);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, wd};
    @(posedge mclk);
    penable <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [10:0] idx, input logic [7:0] wd);
    logic [31:0] rd;
    logic        err;
    xfer(1'b1, idx, wd, rd, err);
    chk(err, 1'b0);
  endtask

  task automatic rdChk(input logic [10:0] idx, input logic [32:0] exp);
    logic [31:0] rd;
    logic        err;
    xfer(1'b0, idx, 8'h00, rd, err);
    chk({err, rd}, exp);
  endtask

  task automatic settle;
    repeat (6) @(posedge mclk);
  endtask

  task automatic t_reset;
    chk({octetsPerFrame, alignSeqTestSelect, alignSeqMultiframes}, {8'h01, 1'b0, 10'd4});
    chk({irq_n, linkSyncRequestOut_n}, 3'b111);
    rdChk(`SLIRQ_IDX_OPF_CFG, 32'h01);
    rdChk(`SLIRQ_IDX_TEST_CTRL, 32'h00);
    rdChk(`SLIRQ_IDX_ILAS_COUNT, 32'h01);
    rdChk(`SLIRQ_IDX_IRQ_VECTOR, 32'h00);
    rdChk(`SLIRQ_IDX_ERR_LIMIT, 32'hff);
    $display("t_reset done");
  endtask

  task automatic t_cfg;
    for (int i = 1; i < 8; i *= 2)
    begin
      wr(`SLIRQ_IDX_OPF_CFG, 8'(i));
      chk(octetsPerFrame, 8'(i));
    end
    wr(`SLIRQ_IDX_OPF_CFG, 8'h03);
    rdChk(`SLIRQ_IDX_OPF_CFG, 32'h04);
    wr(`SLIRQ_IDX_ILAS_COUNT, 8'h03);
    chk(alignSeqMultiframes, 10'd12);
    wr(`SLIRQ_IDX_ILAS_COUNT, 8'h00);
    rdChk(`SLIRQ_IDX_ILAS_COUNT, 32'h03);
    wr(`SLIRQ_IDX_TEST_CTRL, 8'hff);
    rdChk(`SLIRQ_IDX_TEST_CTRL, 32'h88);
    chk({alignSeqTestSelect, thresholdMaskEn}, 2'b11);
    wr(`SLIRQ_IDX_TEST_CTRL, 8'h00);
    chk(alignSeqTestSelect, 1'b0);
    rdChk(11'h474, {1'b1, 32'h0});
    $display("t_cfg done");
  endtask

  // Each error kind in turn, limit three
  task automatic t_errs;
    wr(`SLIRQ_IDX_ERR_LIMIT, 8'h03);
    for (int k = 0; k < 3; k++)
    begin
      u_model.burst(k, k + 2, 2);
      settle;
      rdChk(11'(`SLIRQ_IDX_DISP_LANES + k), 32'h0);
      u_model.burst(k, k + 2, 1);
      settle;
      rdChk(11'(`SLIRQ_IDX_DISP_LANES + k), 32'(1 << (k + 2)));
      rdChk(`SLIRQ_IDX_IRQ_VECTOR, 32'(1 << (7 - k)));
      chk(irq_n, 1'b1);
      wr(`SLIRQ_IDX_IRQ_VECTOR, 8'(1 << (7 - k)));
      settle;
      chk(irq_n, 1'b0);
      wr(`SLIRQ_IDX_IRQ_VECTOR, 8'h00);
      wr(11'(`SLIRQ_IDX_DISP_LANES + k), 8'(1 << (k + 2)));
      settle;
      rdChk(`SLIRQ_IDX_IRQ_VECTOR, 32'h0);
      chk(irq_n, 1'b1);
    end
    $display("t_errs done");
  endtask

  // Each lock kind lost, lanes 5 down to 2
  task automatic t_locks;
    for (int k = 0; k < 4; k++)
    begin
      u_model.setLevel(k, 5 - k, 1'b0);
      settle;
      chk(linkSyncRequestOut_n, k == 0 ? 2'b01 : k == 3 ? 2'b10 : 2'b11);
      rdChk(11'(`SLIRQ_IDX_LOCK_FLAGS + k), 32'(8'hff ^ (8'h01 << (5 - k))));
      rdChk(`SLIRQ_IDX_IRQ_VECTOR, 32'(1 << k));
      wr(`SLIRQ_IDX_IRQ_VECTOR, 8'(1 << k));
      settle;
      chk(irq_n, 1'b0);
      u_model.setLevel(k, 5 - k, 1'b1);
      settle;
      chk(irq_n, 1'b0);
      wr(11'(`SLIRQ_IDX_LOCK_FLAGS + k), 8'h80);
      settle;
      chk(irq_n, 1'b1);
      rdChk(`SLIRQ_IDX_IRQ_VECTOR, 32'h0);
      wr(`SLIRQ_IDX_IRQ_VECTOR, 8'h00);
    end
    $display("t_locks done");
  endtask

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Whole run is a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    $display("ERROR at %0t: watchdog expired", $time);
    report_and_stop;
  end

  initial
  begin
    mismatches = 0;
    testsRun = 0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 13'h0;
    pwdata = 32'h0;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    settle;
    t_reset;
    t_cfg;
    t_errs;
    t_locks;
    report_and_stop;
  end
endmodule // tb

bind slirq_top slirq_top_sva u_sva (
  .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .laneAlignIn(laneAlignIn), .octetsPerFrame(octetsPerFrame),
  .alignSeqTestSelect(alignSeqTestSelect), .thresholdMaskEn(thresholdMaskEn),
  .alignSeqLength(alignSeqLength), .alignSeqMultiframes(alignSeqMultiframes),
  .linkSyncRequestOut_n(linkSyncRequestOut_n), .irq_n(irq_n));
`default_nettype wire
